// [logic/dsuid_regs.vh]
// Contract
// - memory-operation value register, 32-bit, resets zero
// - mailbox 0 at 0x10, read-write, resets zero
// - mailbox 1 at 0x14, same as mailbox 0
// - identification bits 31:28 give processor type
// - identification bits 27:23 give family code
// - identification bits 21:16 give series code
// - identification bits 15:12 give die family
// - identification bits 11:8 give die revision
// - identification bits 7:0 give device select
// - rom entry at 0x1000 with offset, format, present
// - rom entry format bit always reads one
// - mailbox write sets dirty, read clears it
// - rom offset is relative to table base
`ifndef DSUID_REGS_VH
`define DSUID_REGS_VH
`define DSUID_OFF_DATA 14'h000C
`define DSUID_OFF_MBOX0 14'h0010
`define DSUID_OFF_MBOX1 14'h0014
`define DSUID_OFF_CHIPID 14'h0018
`define DSUID_OFF_STATUS 14'h001C
`define DSUID_OFF_ROM0 14'h1000
`define DSUID_RST_WORD 32'h00000000
`define DSUID_RST_PROT 1'b1
`define DSUID_STRAP_WAIT 2'h3
`define DSUID_POS_PROC 28
`define DSUID_POS_FAMILY 23
`define DSUID_POS_SERIES 16
`define DSUID_POS_DIE 12
`define DSUID_POS_REV 8
`define DSUID_POS_DEV_SELECT 0
`define DSUID_POS_COMP_OFFSET 12
`define DSUID_POS_FORMAT 1
`define DSUID_POS_PRES 0
`define DSUID_POS_DIRTY0 0
`define DSUID_POS_DIRTY1 1
`define DSUID_POS_OPDONE 2
`endif

// [logic/dsuid_mailbox.v]
`timescale 1ns/1ps
// one mailbox word with its dirty flag
module dsuid_mailbox #(
  parameter WIDTH = 32
) (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire rd_en,
  input wire [WIDTH-1:0] wdata,
  output reg [WIDTH-1:0] value_q,
  output reg dirty_q
);
  always @(posedge clk) begin
    if (rst) begin
      value_q <= {WIDTH{1'b0}};
      dirty_q <= 1'b0;
    end else begin
      if (wr_en) begin
        value_q <= wdata;
      end
      // a write in the same cycle as a read keeps the flag set
      if (wr_en) begin
        dirty_q <= 1'b1;
      end else if (rd_en) begin
        dirty_q <= 1'b0;
      end
    end
  end
endmodule

// [logic/dsuid_top.v]
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "dsuid_regs.vh"
module dsuid_top #(
  parameter [3:0] PROCESSOR_CODE = 4'h3, // arbitrary value
  parameter [4:0] FAMILY_CODE = 5'h0B, // arbitrary value
  parameter [5:0] SERIES_CODE = 6'h12, // arbitrary value
  parameter [3:0] DIE_CODE = 4'h6, // arbitrary value
  parameter [3:0] REVISION_CODE = 4'h7, // arbitrary value
  parameter [19:0] ROM_COMP_OFFSET = 20'hFF000
) (
  // clock and reset
  input wire CLK,
  input wire RST,
  // apb slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [15:0] PADDR,
  input wire [31:0] PWDATA,
  output wire PREADY,
  output reg [31:0] PRDATA,
  output wire PSLVERR,
  // configuration straps, captured after reset
  input wire [7:0] DEVICE_SELECT_CODE,
  input wire DEVICE_PROTECTED,
  // memory engine result path
  input wire OP_DONE,
  input wire [31:0] OP_RESULT,
  output wire [31:0] MEM_OP_VALUE,
  // mailbox views for the processor side
  output wire [31:0] MAILBOX0,
  output wire [31:0] MAILBOX1,
  output wire [1:0] MAILBOX_DIRTY
);
  reg [1:0] strap_wait_q;
  reg [7:0] dsel_s1_q;
  reg [7:0] dsel_s2_q;
  reg prot_s1_q;
  reg prot_s2_q;
  reg [7:0] dsel_q;
  reg prot_q;
  reg strap_done_q;
  reg done_s1_q;
  reg done_s2_q;
  reg done_prev_q;
  reg op_done_q;
  reg [31:0] data_q;
  wire [31:0] mbox0;
  wire [31:0] mbox1;
  wire dirty0;
  wire dirty1;
  wire [1:0] mbox_hit;
  wire [63:0] mbox_flat;
  wire [1:0] mbox_dirty;
  genvar g;
  wire [13:0] addr;
  wire access;
  wire wr;
  wire rd;
  wire hit_data;
  wire hit_mbox0;
  wire hit_mbox1;
  wire hit_id;
  wire hit_status;
  wire hit_rom;
  wire mapped;
  wire [31:0] chip_id;
  wire [31:0] rom_entry;
  wire done_rise;
  reg [31:0] rdata_d;

  // single-cycle access phase: the slave never waits
  assign PREADY = 1'b1;
  assign addr = PADDR[13:0];
  assign access = PSEL & PENABLE;
  assign wr = access & PWRITE;
  assign rd = access & ~PWRITE;
  assign hit_data = (addr == `DSUID_OFF_DATA) & (PADDR[15:14] == 2'h0);
  assign hit_mbox0 = (addr == `DSUID_OFF_MBOX0) & (PADDR[15:14] == 2'h0);
  assign hit_mbox1 = (addr == `DSUID_OFF_MBOX1) & (PADDR[15:14] == 2'h0);
  assign hit_id = (addr == `DSUID_OFF_CHIPID) & (PADDR[15:14] == 2'h0);
  assign hit_status = (addr == `DSUID_OFF_STATUS) & (PADDR[15:14] == 2'h0);
  assign hit_rom = (addr == `DSUID_OFF_ROM0) & (PADDR[15:14] == 2'h0);
  assign mapped = hit_data | hit_mbox0 | hit_mbox1 | hit_id | hit_status | hit_rom;
  // unmapped addresses and writes to read-only words answer with an error
  assign PSLVERR = access & (~mapped | (PWRITE & (hit_id | hit_rom | hit_status)));

  // straps are pins: synchronise, then latch once after reset
  always @(posedge CLK) begin
    if (RST) begin
      dsel_s1_q <= 8'h00;
      dsel_s2_q <= 8'h00;
      prot_s1_q <= 1'b0;
      prot_s2_q <= 1'b0;
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      strap_wait_q <= 2'h0;
    end else begin
      dsel_s1_q <= DEVICE_SELECT_CODE;
      dsel_s2_q <= dsel_s1_q;
      prot_s1_q <= DEVICE_PROTECTED;
      prot_s2_q <= prot_s1_q;
      done_s1_q <= OP_DONE;
      done_s2_q <= done_s1_q;
      if (strap_wait_q != `DSUID_STRAP_WAIT) begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // capture after the synchroniser has filled
  always @(posedge CLK) begin
    if (RST) begin
      dsel_q <= 8'h00;
      prot_q <= `DSUID_RST_PROT;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q && strap_wait_q == `DSUID_STRAP_WAIT) begin
      dsel_q <= dsel_s2_q;
      prot_q <= prot_s2_q;
      strap_done_q <= 1'b1;
    end
  end

  assign done_rise = done_s2_q & ~done_prev_q;

  // memory operation value: software seed, engine result on completion
  always @(posedge CLK) begin
    if (RST) begin
      data_q <= `DSUID_RST_WORD;
      done_prev_q <= 1'b0;
      op_done_q <= 1'b0;
    end else begin
      done_prev_q <= done_s2_q;
      if (done_rise) begin
        data_q <= OP_RESULT;
      end else if (wr && hit_data) begin
        data_q <= PWDATA;
      end
      // completion wins over a clearing write in the same cycle
      if (done_rise) begin
        op_done_q <= 1'b1;
      end else if (wr && hit_status && PWDATA[`DSUID_POS_OPDONE]) begin
        op_done_q <= 1'b0;
      end
    end
  end

  assign mbox_hit = {hit_mbox1, hit_mbox0};

  // one mailbox per channel; both ends of the debug link share each word
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_mbox
      dsuid_mailbox #(
        .WIDTH(32)
      ) u_mbox (
        .clk(CLK),
        .rst(RST),
        .wr_en(wr & mbox_hit[g]),
        .rd_en(rd & mbox_hit[g]),
        .wdata(PWDATA),
        .value_q(mbox_flat[32*g+31:32*g]),
        .dirty_q(mbox_dirty[g])
      );
    end
  endgenerate

  assign mbox0 = mbox_flat[31:0];
  assign mbox1 = mbox_flat[63:32];
  assign dirty0 = mbox_dirty[0];
  assign dirty1 = mbox_dirty[1];

  assign chip_id = ({28'h0, PROCESSOR_CODE} << `DSUID_POS_PROC)
    | ({27'h0, FAMILY_CODE} << `DSUID_POS_FAMILY)
    | ({26'h0, SERIES_CODE} << `DSUID_POS_SERIES)
    | ({28'h0, DIE_CODE} << `DSUID_POS_DIE)
    | ({28'h0, REVISION_CODE} << `DSUID_POS_REV)
    | ({24'h0, dsel_q} << `DSUID_POS_DEV_SELECT);

  // offset is relative to the table base; entry present only when protected
  assign rom_entry = ({12'h0, ROM_COMP_OFFSET} << `DSUID_POS_COMP_OFFSET)
    | (32'h1 << `DSUID_POS_FORMAT)
    | ({31'h0, prot_q} << `DSUID_POS_PRES);

  always @* begin
    rdata_d = 32'h00000000;
    if (hit_data) begin
      rdata_d = data_q;
    end else if (hit_mbox0) begin
      rdata_d = mbox0;
    end else if (hit_mbox1) begin
      rdata_d = mbox1;
    end else if (hit_id) begin
      rdata_d = chip_id;
    end else if (hit_rom) begin
      rdata_d = rom_entry;
    end else if (hit_status) begin
      rdata_d = {29'h0, op_done_q, dirty1, dirty0};
    end
  end

  // read data registered in the setup cycle so it is valid in the access phase
  always @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata_d;
    end
  end

  assign MEM_OP_VALUE = data_q;
  assign MAILBOX0 = mbox0;
  assign MAILBOX1 = mbox1;
  assign MAILBOX_DIRTY = {dirty1, dirty0};
endmodule

// [test/dsuid_monitor.sv]
`timescale 1ns/1ps
module dsuid_monitor (
  // watched top ports
  input wire CLK,
  input wire RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [15:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PSLVERR,
  input wire OP_DONE,
  input wire [31:0] OP_RESULT,
  input wire [31:0] MEM_OP_VALUE,
  input wire [31:0] MAILBOX0,
  input wire [31:0] MAILBOX1,
  input wire [1:0] MAILBOX_DIRTY
);
  default clocking dcb @(posedge CLK); endclocking
  default disable iff (RST);
  wire wr = PSEL && PENABLE && PWRITE;
  wire rd = PSEL && PENABLE && !PWRITE;
  // engine result wins, so only a write with no synced edge in flight must land
  sequence s_quiet;
    (!OP_DONE) [*4];
  endsequence
  sequence s_data_wr;
    wr && PADDR == 16'h000C;
  endsequence
  AST_DATA_WR:
    assert property (s_quiet ##0 s_data_wr |=> MEM_OP_VALUE == $past(PWDATA)) else $error("data write lost");
  AST_RESULT:
    assert property ($rose(OP_DONE) |-> ##[2:6] MEM_OP_VALUE == OP_RESULT) else $error("result not loaded");
  AST_MBOX0_WR:
    assert property (wr && PADDR == 16'h0010 |=> MAILBOX0 == $past(PWDATA) && MAILBOX_DIRTY[0]) else $error("mbox0");
  AST_MBOX1_WR:
    assert property (wr && PADDR == 16'h0014 |=> MAILBOX1 == $past(PWDATA) && MAILBOX_DIRTY[1]) else $error("mbox1");
  AST_DIRTY_CLR:
    assert property (rd && PADDR == 16'h0010 |=> !MAILBOX_DIRTY[0]) else $error("dirty not cleared");
  AST_MBOX_RD:
    assert property (rd && PADDR == 16'h0014 |-> PRDATA == MAILBOX1) else $error("mbox1 read wrong");
  AST_FMT:
    assert property (rd && PADDR == 16'h1000 |-> PRDATA[1]) else $error("rom format bit low");
  AST_RO_WR:
    assert property (wr && (PADDR == 16'h0018 || PADDR == 16'h1000) |-> PSLVERR) else $error("ro write taken");
endmodule
bind dsuid_top dsuid_monitor i_dsuid_monitor (.*);

// [test/dsuid_engine_model.sv]
`timescale 1ns/1ps
// engine stand-in: result steady while done is high, scrambled after
module dsuid_engine_model (
  // bench control and result path
  input wire CLK,
  input wire go,
  input wire [31:0] value,
  input wire [7:0] lat,
  output reg OP_DONE = 1'b0,
  output reg [31:0] OP_RESULT = 32'h0
);
  integer n = -1;
  always @(posedge CLK) begin
    if (go) begin
      n <= lat + 8;
      OP_RESULT <= value;
    end else if (n > 0) begin
      n <= n - 1;
      OP_DONE <= (n <= 8);
    end else if (n == 0) begin
      n <= -1;
      OP_DONE <= 1'b0;
      OP_RESULT <= ~OP_RESULT;
    end
  end
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, slv;
  reg [15:0] paddr = 16'h0000;
  reg [31:0] pwdata = 32'h0, val = 32'h0, rd, lf = 32'h00011FEF;
  reg [31:0] mdl [3:5];
  reg [7:0] lat = 8'h00, strap_sel = 8'h5A;
  reg strap_prot = 1'b0;
  wire pready, pslverr, op_done;
  wire [31:0] prdata, mem_val, mb0, mb1, op_res;
  wire [1:0] dirty;
  integer failures = 0, total_checks = 0, i, j;
  dsuid_top #(.PROCESSOR_CODE(4'hA), .FAMILY_CODE(5'h13), .SERIES_CODE(6'h2C), .DIE_CODE(4'h9),
    .REVISION_CODE(4'h5), .ROM_COMP_OFFSET(20'h3C5A7)) i_dsuid_top (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .DEVICE_SELECT_CODE(strap_sel), .DEVICE_PROTECTED(strap_prot), .OP_DONE(op_done),
    .OP_RESULT(op_res), .MEM_OP_VALUE(mem_val), .MAILBOX0(mb0), .MAILBOX1(mb1), .MAILBOX_DIRTY(dirty));
  dsuid_engine_model i_dsuid_engine_model (.CLK(clk), .go(go), .value(val), .lat(lat), .OP_DONE(op_done),
    .OP_RESULT(op_res));
  initial forever #20 clk = ~clk;
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [15:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      if (failures == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // limit far above the fewer than two hundred cycles the sequence needs
  initial begin
    repeat (3000) @(posedge clk);
    failures = failures + 1;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (i = 3; i < 6; i = i + 1) begin
      mdl[i] = 32'h0;
      apb(1'b0, 16'(i * 4), 32'h0);
      chk(rd, mdl[i]);
    end
    for (i = 0; i < 6; i = i + 1) begin
      lf = nxt(lf);
      mdl[3 + i % 3] = lf;
      apb(1'b1, 16'(12 + 4 * (i % 3)), lf);
      @(negedge clk);
      chk(dirty, i % 3);
      apb(1'b0, 16'(12 + 4 * (i % 3)), 32'h0);
      chk(rd, mdl[3 + i % 3]);
      @(negedge clk);
      chk(dirty, 32'h0);
    end
    chk(mb0, mdl[4]);
    chk(mb1, mdl[5]);
    // straps move after the latch; the identification must not follow
    strap_sel <= 8'hA5;
    for (i = 0; i < 2; i = i + 1) begin
      apb(1'b0, 16'h0018, 32'h0);
      chk(rd & 32'hFFBFFFFF, {4'hA, 5'h13, 1'b0, 6'h2C, 4'h9, 4'h5, 8'h5A});
      apb(1'b0, 16'h1000, 32'h0);
      chk(rd & 32'hFFFFF003, {20'h3C5A7, 10'h000, 2'b10});
      apb(1'b1, 16'h0018 + 16'(i * 4072), 32'hFFFFFFFF);
      chk(slv, 32'h1);
    end
    apb(1'b0, 16'h0100, 32'h0);
    chk(slv, 32'h1);
    for (i = 0; i < 2; i = i + 1) begin
      lf = nxt(lf);
      mdl[3] = lf;
      val <= lf;
      lat <= 8'(i * 20);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (j = 0; j < 60 && mem_val !== mdl[3]; j = j + 1) @(posedge clk);
      chk(mem_val, mdl[3]);
      apb(1'b0, 16'h000C, 32'h0);
      chk(rd, mdl[3]);
    end
    apb(1'b0, 16'h001C, 32'h0);
    chk(rd, 32'h4);
    apb(1'b1, 16'h001C, 32'h4);
    apb(1'b0, 16'h001C, 32'h0);
    chk(rd, 32'h0);
    // second reset with new straps: the latch must take them again
    rst <= 1'b1;
    strap_prot <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    chk(mem_val, 32'h0);
    apb(1'b0, 16'h0010, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 16'h0018, 32'h0);
    chk(rd & 32'hFF, 32'hA5);
    apb(1'b0, 16'h1000, 32'h0);
    chk(rd & 32'h3, 32'h3);
    tally_and_finish;
  end
endmodule
